// ### core/branch_condition_and_memory_port.sv
// Branch evaluation, next-address choice and main-memory port registers.
`default_nettype none
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module branch_condition_and_memory_port #(
   parameter int STACK_D = 4
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic [15:0] fetch_addr_o,
   input wire brmem_pkg::uinst_s uinst_i,
   output logic exec_o,
   input wire logic [23:0] bus_i,
   input wire logic carry18_i,
   input wire logic carry19_i,
   input wire logic [1:0] xreg_sel_i,
   output logic [23:0] xreg_data_o,
   input wire logic in_waiting_i,
   input wire logic out_pending_i,
   output logic mem_req_o,
   output brmem_pkg::mem_op_s mem_op_o,
   output logic [23:0] mem_addr_o,
   output logic [23:0] mem_wdata_o,
   input wire logic [23:0] mem_rdata_i,
   input wire logic mem_rflag_i
);
   localparam int SP_W = (STACK_D > 1) ? $clog2(STACK_D) : 1;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic run_q, squash_q, req_q;
   logic [15:0] mpc_q, mpc_d;
   logic [SP_W-1:0] sp_q;
   logic [15:0] stk_q [STACK_D];
   logic [23:0] mar_q, mir_q, head_q, tail_q;
   logic head_flag_q, tail_flag_q;
   brmem_pkg::mem_op_s op_q;
   logic in_s1_q, in_s2_q, out_s1_q, out_s2_q;
   logic [31:0] prdata_q;

   // ----------------------------------------------------------------
   // Condition evaluation
   // ----------------------------------------------------------------
   function automatic logic cond_eval(input logic [4:0] c,
      input logic [23:0] v, input logic [3:0] imm, input logic cy,
      input logic ov, input logic inw, input logic outp, input logic hf,
      input logic tf);
      logic [3:0] t;
      logic dz;
      logic r;
      t = v[brmem_pkg::TAG_LSB +: brmem_pkg::TAG_W];
      dz = (v[brmem_pkg::DATA_W-1:0] == '0);
      r = 1'b0;
      case (c)
         brmem_pkg::C_ALL_ZERO: r = (v == '0);
         brmem_pkg::C_ANY_NZ: r = (v != '0);
         brmem_pkg::C_VAL_ZERO: r = dz;
         brmem_pkg::C_VAL_NZ: r = ~dz;
         brmem_pkg::C_SIGN_CLR: r = ~v[brmem_pkg::SIGN_BIT];
         brmem_pkg::C_SIGN_SET: r = v[brmem_pkg::SIGN_BIT];
         brmem_pkg::C_OVF_SET: r = ov;
         brmem_pkg::C_OVF_CLR: r = ~ov;
         brmem_pkg::C_CRY_SET: r = cy;
         brmem_pkg::C_CRY_CLR: r = ~cy;
         brmem_pkg::C_IN_WAIT: r = inw;
         brmem_pkg::C_NO_INPUT: r = ~inw;
         brmem_pkg::C_OUT_PEND: r = outp;
         brmem_pkg::C_OUT_FREE: r = ~outp;
         brmem_pkg::C_TAG_EQ: r = (t == imm);
         brmem_pkg::C_TAG_NE: r = (t != imm);
         brmem_pkg::C_TAG_GE: r = (t >= imm);
         brmem_pkg::C_TAG_LT: r = (t < imm);
         brmem_pkg::C_HEAD_ONE: r = hf;
         brmem_pkg::C_HEAD_ZERO: r = ~hf;
         brmem_pkg::C_TAIL_ONE: r = tf;
         brmem_pkg::C_TAIL_ZERO: r = ~tf;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : cond_eval

   // ----------------------------------------------------------------
   // Decode and selection
   // ----------------------------------------------------------------
   // Read data from a cycle started last instruction bypasses the
   // output registers, so the next instruction sees it at once.
   wire logic cap_head = req_q & ~op_q.tail;
   wire logic cap_tail = req_q & op_q.tail;
   wire logic [23:0] head_now = cap_head ? mem_rdata_i : head_q;
   wire logic [23:0] tail_now = cap_tail ? mem_rdata_i : tail_q;
   wire logic hflag_now = cap_head ? mem_rflag_i : head_flag_q;
   wire logic tflag_now = cap_tail ? mem_rflag_i : tail_flag_q;
   wire logic [3:0] bus_tag = bus_i[brmem_pkg::TAG_LSB +: brmem_pkg::TAG_W];
   wire logic carry = carry19_i;
   wire logic ovf = carry18_i ^ carry19_i;
   wire logic exec = run_q & ~squash_q;
   wire logic is_forced_tag_jump = (uinst_i.jump == brmem_pkg::J_FORCED_TAG_JUMP);
   wire logic [3:0] fj_tag = {brmem_pkg::FORCED_TAG_JUMP_HI, uinst_i.forced_tag_jump_tag};
   wire logic forced_tag_jump_hit = exec & is_forced_tag_jump & (bus_tag == fj_tag);
   wire logic cond_true = cond_eval(uinst_i.cond, bus_i, uinst_i.imm_tag,
      carry, ovf, in_s2_q, out_s2_q, hflag_now, tflag_now);
   wire logic br_taken = exec & ~forced_tag_jump_hit & cond_true;
   wire logic push = exec & ~forced_tag_jump_hit & ~br_taken &
      (uinst_i.jump == brmem_pkg::J_JSR);
   wire logic pop = exec & ~forced_tag_jump_hit & ~br_taken &
      (uinst_i.jump == brmem_pkg::J_RTS);
   wire logic [SP_W-1:0] sp_d = push ? sp_q + SP_W'(1) :
      pop ? sp_q - SP_W'(1) : sp_q;
   wire logic [15:0] mpc_inc = mpc_q + 16'h0001;
   wire logic [15:0] br_dest = {mpc_q[brmem_pkg::PC_W-1:brmem_pkg::BR_W],
      uinst_i.target[brmem_pkg::BR_W-1:0]};

   // APB decode; the setup phase latches read data so that the access
   // phase can answer from a flip-flop with no wait state.
   wire logic hit_ctrl = (paddr_i == brmem_pkg::REG_CTRL);
   wire logic hit_start = (paddr_i == brmem_pkg::REG_START);
   wire logic hit_stat = (paddr_i == brmem_pkg::REG_STATUS);
   wire logic hit_mpc = (paddr_i == brmem_pkg::REG_MPC);
   wire logic mapped = hit_ctrl | hit_start | hit_stat | hit_mpc;
   wire logic setup = psel_i & ~penable_i;
   wire logic wr = psel_i & penable_i & pwrite_i & mapped;
   wire logic ctrl_wr = wr & hit_ctrl;
   wire logic start_wr = wr & hit_start;
   wire logic [31:0] rd_mux =
      hit_ctrl ? 32'(run_q) :
      hit_stat ? 32'({sp_q, 2'h0, req_q, tail_flag_q, head_flag_q,
         out_s2_q, in_s2_q, squash_q}) :
      hit_mpc ? 32'(mpc_q) : '0;

   // ----------------------------------------------------------------
   // Next address
   // ----------------------------------------------------------------
   // The counter moves only on executed words or a start write; a squashed word holds it,
   // which is the one cycle paid for a late-resolved transfer.
   always_comb
   begin
      mpc_d = mpc_q;
      if (start_wr)
      begin
         mpc_d = pwdata_i[brmem_pkg::PC_W-1:0];
      end
      else if (forced_tag_jump_hit)
      begin
         mpc_d = bus_i[brmem_pkg::PC_W-1:0];
      end
      else if (br_taken)
      begin
         mpc_d = br_dest;
      end
      else if (exec)
      begin
         case (uinst_i.jump)
            brmem_pkg::J_JMP: mpc_d = uinst_i.target;
            brmem_pkg::J_JSR: mpc_d = uinst_i.target;
            brmem_pkg::J_RTS: mpc_d = stk_q[sp_q];
            default: mpc_d = mpc_inc;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sequencer registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mpc_q <= brmem_pkg::MPC_RST;
         squash_q <= 1'b0;
         sp_q <= '0;
      end
      else
      begin
         mpc_q <= mpc_d;
         squash_q <= ~start_wr & (forced_tag_jump_hit | br_taken);
         sp_q <= sp_d;
      end
   end

   // The stack is circular: a fifth nested call overwrites the oldest
   // return address, as the small hardware stack does.
   genvar gi;
   generate
      for (gi = 0; gi < STACK_D; gi++)
      begin : g_stk
         always_ff @(posedge ref_clk_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
            begin
               stk_q[gi] <= brmem_pkg::MPC_RST;
            end
            else if (push && (sp_d == SP_W'(gi)))
            begin
               stk_q[gi] <= mpc_inc;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Memory port registers
   // ----------------------------------------------------------------
   // The request leaves one edge late so that an address or input
   // loaded by the same word is already in place.
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mar_q <= '0;
         mir_q <= '0;
         req_q <= 1'b0;
         op_q <= '0;
      end
      else
      begin
         if (exec && uinst_i.mar_load)
         begin
            mar_q <= bus_i;
         end
         if (exec && uinst_i.mir_load)
         begin
            mir_q <= bus_i;
         end
         req_q <= exec & uinst_i.mem.start;
         op_q <= uinst_i.mem;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         head_q <= '0;
         tail_q <= '0;
         head_flag_q <= 1'b0;
         tail_flag_q <= 1'b0;
         in_s1_q <= 1'b0;
         in_s2_q <= 1'b0;
         out_s1_q <= 1'b0;
         out_s2_q <= 1'b0;
      end
      else
      begin
         head_q <= head_now;
         tail_q <= tail_now;
         head_flag_q <= hflag_now;
         tail_flag_q <= tflag_now;
         // Host flags are asynchronous; only the second stage is read.
         in_s1_q <= in_waiting_i;
         in_s2_q <= in_s1_q;
         out_s1_q <= out_pending_i;
         out_s2_q <= out_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         run_q <= brmem_pkg::CTRL_RST;
         prdata_q <= '0;
      end
      else
      begin
         if (ctrl_wr)
         begin
            run_q <= pwdata_i[0];
         end
         if (setup)
         begin
            prdata_q <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Only fetch reads the store; nothing here writes it.
   assign fetch_addr_o = mpc_q;
   assign exec_o = exec;
   assign prdata_o = prdata_q;
   assign pready_o = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & ~mapped;
   assign mem_req_o = req_q;
   assign mem_op_o = op_q;
   assign mem_addr_o = mar_q;
   assign mem_wdata_o = mir_q;
   assign xreg_data_o =
      (xreg_sel_i == brmem_pkg::X_HEAD) ? head_now :
      (xreg_sel_i == brmem_pkg::X_TAIL) ? tail_now :
      (xreg_sel_i == brmem_pkg::X_MPC) ?
         {brmem_pkg::TAG_MPC, brmem_pkg::PAD_MPC, mpc_inc} :
      mir_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_forced_tag_jump_and_branch;
      exec && is_forced_tag_jump && !forced_tag_jump_hit && cond_true && !start_wr;
   endsequence

   sequence s_head_cycle;
      exec && uinst_i.mem.start && !uinst_i.mem.tail ##1 1'b1;
   endsequence

   AST_FORCED_TAG_JUMP_WINS: assert property (
      forced_tag_jump_hit && !start_wr |=> mpc_q == $past(bus_i[15:0]) && squash_q
   ) else $error("forced jump did not load bus data");
   AST_FORCED_TAG_JUMP_MISS: assert property (
      s_forced_tag_jump_and_branch |=> mpc_q[11:0] == $past(uinst_i.target[11:0])
   ) else $error("branch ignored after forced tag mismatch");
   AST_ALL_ZERO: assert property (
      exec && !is_forced_tag_jump && uinst_i.cond == brmem_pkg::C_ALL_ZERO
      |-> br_taken == (bus_i == 24'h000000)
   ) else $error("all zero branch wrong");
   AST_SIGN: assert property (
      exec && !is_forced_tag_jump && uinst_i.cond == brmem_pkg::C_SIGN_SET
      |-> br_taken == bus_i[19]
   ) else $error("sign branch wrong");
   AST_OVF: assert property (
      exec && !is_forced_tag_jump && uinst_i.cond == brmem_pkg::C_OVF_SET
      |-> br_taken == (carry18_i ^ carry19_i)
   ) else $error("overflow branch wrong");
   AST_TAG_GE: assert property (
      exec && !is_forced_tag_jump && uinst_i.cond == brmem_pkg::C_TAG_GE
      |-> br_taken == (bus_i[23:20] >= uinst_i.imm_tag)
   ) else $error("tag magnitude branch wrong");
   AST_BR_HIGH: assert property (
      br_taken && !start_wr |=> mpc_q[15:12] == $past(mpc_q[15:12])
      && !exec
   ) else $error("branch changed high counter bits or lost no cycle");
   AST_RTS_HOLD: assert property (
      br_taken && uinst_i.jump == brmem_pkg::J_RTS |=> $stable(sp_q)
   ) else $error("return stack popped on taken branch");
   AST_NO_LOSS: assert property (
      exec && uinst_i.jump == brmem_pkg::J_JMP && !cond_true && !start_wr
      |=> !squash_q && mpc_q == $past(uinst_i.target)
   ) else $error("unconditional jump lost a cycle");

   AST_MAR: assert property (
      exec && uinst_i.mar_load |=> mem_addr_o == $past(bus_i)
   ) else $error("address register missed bus value");

   AST_MEM_NEXT: assert property (
      s_head_cycle |-> mem_req_o && head_now == mem_rdata_i
   ) else $error("head data not visible to next word");
endmodule : branch_condition_and_memory_port
`default_nettype wire

// ### include/brmem_pkg.sv
// Package of constants and types for the branch and memory port block.
`default_nettype none
package brmem_pkg;
   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam int DATA_W = 20;
   localparam int TAG_W = 4;
   localparam int TAG_LSB = 20;
   localparam int SIGN_BIT = 19;
   localparam int PC_W = 16;
   localparam int BR_W = 12;
   localparam int IDX_W = 12;
   localparam logic [1:0] FORCED_TAG_JUMP_HI = 2'h3;
   localparam logic [3:0] TAG_MPC = 4'hf;
   localparam logic [3:0] PAD_MPC = 4'h0;
   localparam logic [15:0] MPC_RST = 16'h0000;
   localparam logic CTRL_RST = 1'b1;

   // ----------------------------------------------------------------
   // Branch conditions
   // ----------------------------------------------------------------
   localparam logic [4:0] C_NONE = 5'h00;
   localparam logic [4:0] C_ALL_ZERO = 5'h01;
   localparam logic [4:0] C_ANY_NZ = 5'h02;
   localparam logic [4:0] C_VAL_ZERO = 5'h03;
   localparam logic [4:0] C_VAL_NZ = 5'h04;
   localparam logic [4:0] C_SIGN_CLR = 5'h05;
   localparam logic [4:0] C_SIGN_SET = 5'h06;
   localparam logic [4:0] C_OVF_SET = 5'h07;
   localparam logic [4:0] C_OVF_CLR = 5'h08;
   localparam logic [4:0] C_CRY_SET = 5'h09;
   localparam logic [4:0] C_CRY_CLR = 5'h0a;
   localparam logic [4:0] C_IN_WAIT = 5'h0b;
   localparam logic [4:0] C_NO_INPUT = 5'h0c;
   localparam logic [4:0] C_OUT_PEND = 5'h0d;
   localparam logic [4:0] C_OUT_FREE = 5'h0e;
   localparam logic [4:0] C_TAG_EQ = 5'h0f;
   localparam logic [4:0] C_TAG_NE = 5'h10;
   localparam logic [4:0] C_TAG_GE = 5'h11;
   localparam logic [4:0] C_TAG_LT = 5'h12;
   localparam logic [4:0] C_HEAD_ONE = 5'h13;
   localparam logic [4:0] C_HEAD_ZERO = 5'h14;
   localparam logic [4:0] C_TAIL_ONE = 5'h15;
   localparam logic [4:0] C_TAIL_ZERO = 5'h16;

   // ----------------------------------------------------------------
   // Jump kinds, external register selects, bus map
   // ----------------------------------------------------------------
   localparam logic [2:0] J_NONE = 3'h0;
   localparam logic [2:0] J_JMP = 3'h1;
   localparam logic [2:0] J_JSR = 3'h2;
   localparam logic [2:0] J_RTS = 3'h3;
   localparam logic [2:0] J_FORCED_TAG_JUMP = 3'h4;
   localparam logic [1:0] X_MIR = 2'h0;
   localparam logic [1:0] X_HEAD = 2'h1;
   localparam logic [1:0] X_TAIL = 2'h2;
   localparam logic [1:0] X_MPC = 2'h3;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_START = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_MPC = 12'h00c;

   typedef struct packed {
      logic start;
      logic xchg;
      logic tail;
      logic flag_wr;
      logic flag_val;
   } mem_op_s;

   typedef struct packed {
      logic [4:0] cond;
      logic [3:0] imm_tag;
      logic [2:0] jump;
      logic [1:0] forced_tag_jump_tag;
      logic [15:0] target;
      mem_op_s mem;
      logic mar_load;
      logic mir_load;
   } uinst_s;
endpackage : brmem_pkg
`default_nettype wire

// ### verification/branch_condition_and_memory_port_tb.sv
// Self-checking bench for the branch and memory port block.
`default_nettype none
module branch_condition_and_memory_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o;
   logic pslverr_o, exec_o, carry18_i, carry19_i, mem_req_o, er;
   logic in_waiting_i, out_pending_i, host_in, host_out, mem_rflag_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [15:0] fetch_addr_o, pc, ret;
   logic [1:0] xreg_sel_i, xs;
   logic [23:0] bus_i, xreg_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
   brmem_pkg::uinst_s uinst_i, w;
   brmem_pkg::mem_op_s mem_op_o;
   int err_total, tests_run;
   branch_condition_and_memory_port branch_condition_and_memory_port_inst (
      .ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .fetch_addr_o, .uinst_i,
      .exec_o, .bus_i, .carry18_i, .carry19_i, .xreg_sel_i, .xreg_data_o,
      .in_waiting_i, .out_pending_i, .mem_req_o, .mem_op_o, .mem_addr_o,
      .mem_wdata_o, .mem_rdata_i, .mem_rflag_i);
   mem_host_model mem_host_model_inst (.ref_clk_i, .mem_req_i(mem_req_o),
      .mem_op_i(mem_op_o), .mem_addr_i(mem_addr_o),
      .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
      .mem_rflag_o(mem_rflag_i), .host_in_i(host_in),
      .host_out_i(host_out), .in_waiting_o(in_waiting_i),
      .out_pending_o(out_pending_i));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 16);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1)
      begin
         err_total++;
         summarize();
      end
   endtask : apb
   // Kind: 0 falls through, 1 branch, 2 forced load, 3 lossless to alt.
   task automatic run(input logic [23:0] v, input logic [1:0] cy,
         input int k, input logic [15:0] alt);
      logic [15:0] e;
      @(posedge ref_clk_i);
      uinst_i <= w;
      bus_i <= v;
      xreg_sel_i <= xs;
      {carry18_i, carry19_i} <= cy;
      #1;
      pc = fetch_addr_o;
      chk(exec_o, 1'b1);
      @(posedge ref_clk_i);
      uinst_i <= '0;
      #1;
      e = k == 0 ? pc + 16'h1 : k == 1 ? {pc[15:12], w.target[11:0]}
         : k == 2 ? v[15:0] : alt;
      chk(fetch_addr_o, e);
      chk(exec_o, k == 0 || k == 3);
   endtask : run
   task automatic br(input logic [4:0] c, input logic [23:0] v,
         input logic [3:0] im, input logic [1:0] cy, input logic t);
      w = '0;
      w.cond = c;
      w.imm_tag = im;
      w.target = 16'h0abc;
      run(v, cy, t ? 1 : 0, 16'h0);
   endtask : br
   // Pointers keep tag 0, within the recommended range.
   task automatic mem(input logic [4:0] op, input logic [23:0] a,
         input logic [23:0] d, input logic [23:0] old);
      w = '0;
      w.mir_load = 1'b1;
      xs = brmem_pkg::X_MIR;
      run(d, 2'h0, 0, 16'h0);
      chk(xreg_data_o, d);
      w = '0;
      w.mar_load = 1'b1;
      w.mem = op;
      xs = op[2] ? brmem_pkg::X_TAIL : brmem_pkg::X_HEAD;
      run(a, 2'h0, 0, 16'h0);
      chk(mem_req_o, 1'b1);
      chk(mem_op_o, op);
      chk(mem_addr_o, a);
      chk(mem_wdata_o, d);
      chk(xreg_data_o, old);
   endtask : mem
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial
   begin
      err_total = 0;
      tests_run = 0;
      {sys_rst_i, psel_i, penable_i, pwrite_i, carry18_i, carry19_i} = 6'h20;
      {host_in, host_out, paddr_i, pwdata_i, bus_i, xreg_sel_i, xs} = '0;
      uinst_i = '0;
      w = '0;
      repeat (8) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      apb(1'b0, brmem_pkg::REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
      chk(32'(er), 32'h1);
      apb(1'b1, brmem_pkg::REG_START, 32'h5ff0);
      br(brmem_pkg::C_ALL_ZERO, 24'h000000, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_ALL_ZERO, 24'h100000, 4'h0, 2'h0, 1'b0);
      br(brmem_pkg::C_ANY_NZ, 24'h100000, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_VAL_ZERO, 24'h100000, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_VAL_NZ, 24'h100000, 4'h0, 2'h0, 1'b0);
      br(brmem_pkg::C_VAL_NZ, 24'h000001, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_SIGN_CLR, 24'hf7ffff, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_SIGN_SET, 24'h080000, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_SIGN_SET, 24'h07ffff, 4'h0, 2'h0, 1'b0);
      br(brmem_pkg::C_OVF_SET, 24'h0, 4'h0, 2'h2, 1'b1);
      br(brmem_pkg::C_OVF_SET, 24'h0, 4'h0, 2'h3, 1'b0);
      br(brmem_pkg::C_OVF_CLR, 24'h0, 4'h0, 2'h3, 1'b1);
      br(brmem_pkg::C_CRY_SET, 24'h0, 4'h0, 2'h1, 1'b1);
      br(brmem_pkg::C_CRY_CLR, 24'h0, 4'h0, 2'h1, 1'b0);
      br(brmem_pkg::C_CRY_CLR, 24'h0, 4'h0, 2'h2, 1'b1);
      br(brmem_pkg::C_TAG_EQ, 24'h900000, 4'h9, 2'h0, 1'b1);
      br(brmem_pkg::C_TAG_NE, 24'h900000, 4'h9, 2'h0, 1'b0);
      br(brmem_pkg::C_TAG_GE, 24'hf00000, 4'h7, 2'h0, 1'b1);
      br(brmem_pkg::C_TAG_LT, 24'hf00000, 4'h7, 2'h0, 1'b0);
      br(brmem_pkg::C_TAG_LT, 24'h700000, 4'h8, 2'h0, 1'b1);
      br(brmem_pkg::C_NONE, 24'h0, 4'h0, 2'h0, 1'b0);
      host_in <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      br(brmem_pkg::C_IN_WAIT, 24'h0, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_OUT_FREE, 24'h0, 4'h0, 2'h0, 1'b1);
      {host_in, host_out} <= 2'h1;
      repeat (4) @(posedge ref_clk_i);
      br(brmem_pkg::C_NO_INPUT, 24'h0, 4'h0, 2'h0, 1'b1);
      br(brmem_pkg::C_OUT_PEND, 24'h0, 4'h0, 2'h0, 1'b1);
      mem(5'h10, 24'h3, 24'h0abcde, 24'h100003);
      br(brmem_pkg::C_HEAD_ZERO, 24'h0, 4'h0, 2'h0, 1'b1);
      mem(5'h1b, 24'h3, 24'h0abcde, 24'h100003);
      mem(5'h10, 24'h3, 24'h012345, 24'h0abcde);
      br(brmem_pkg::C_HEAD_ONE, 24'h0, 4'h0, 2'h0, 1'b1);
      mem(5'h16, 24'h5, 24'h0, 24'h200005);
      br(brmem_pkg::C_TAIL_ONE, 24'h0, 4'h0, 2'h0, 1'b1);
      mem(5'h14, 24'h5, 24'h0, 24'h200005);
      br(brmem_pkg::C_TAIL_ZERO, 24'h0, 4'h0, 2'h0, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         w = '0;
         w.jump = brmem_pkg::J_FORCED_TAG_JUMP;
         w.forced_tag_jump_tag = 2'(k);
         w.cond = brmem_pkg::C_ANY_NZ;
         run({4'(12 + k), 20'h04321}, 2'h0, 2, 16'h0);
      end
      run(24'hd04321, 2'h0, 1, 16'h0);
      w.cond = brmem_pkg::C_ALL_ZERO;
      run(24'hd04321, 2'h0, 0, 16'h0);
      w = '0;
      w.jump = brmem_pkg::J_JSR;
      w.target = 16'h1234;
      run(24'h0, 2'h0, 3, 16'h1234);
      ret = pc + 16'h1;
      w.jump = brmem_pkg::J_RTS;
      w.cond = brmem_pkg::C_ALL_ZERO;
      run(24'h0, 2'h0, 1, 16'h0);
      run(24'h1, 2'h0, 3, ret);
      w = '0;
      w.jump = brmem_pkg::J_JMP;
      w.target = 16'h2468;
      run(24'h0, 2'h0, 3, 16'h2468);
      apb(1'b1, brmem_pkg::REG_CTRL, 32'h0);
      w.mem.start = 1'b1;
      @(posedge ref_clk_i);
      uinst_i <= w;
      #1;
      pc = fetch_addr_o;
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk({fetch_addr_o, exec_o, mem_req_o}, {pc, 2'h0});
      summarize();
   end
endmodule : branch_condition_and_memory_port_tb
`default_nettype wire

// ### verification/mem_host_model.sv
// Far-side model: main memory nodes and host port flags.
`default_nettype none
module mem_host_model (
   input wire logic ref_clk_i,
   input wire logic mem_req_i,
   input wire brmem_pkg::mem_op_s mem_op_i,
   input wire logic [23:0] mem_addr_i,
   input wire logic [23:0] mem_wdata_i,
   output logic [23:0] mem_rdata_o,
   output logic mem_rflag_o,
   input wire logic host_in_i,
   input wire logic host_out_i,
   output logic in_waiting_o,
   output logic out_pending_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Node store
   // ----------------------------------------------------------------
   logic [23:0] word_q [2][16];
   logic flag_q [2][16];
   logic [3:0] a;
   logic t;
   assign a = mem_addr_i[3:0];
   assign t = mem_op_i.tail;
   // Idle lines show the inverse, so a stale read cannot pass.
   assign mem_rdata_o = mem_req_i ? word_q[t][a] : ~word_q[t][a];
   assign mem_rflag_o = mem_req_i ? flag_q[t][a] : ~flag_q[t][a];
   initial
   begin
      for (int i = 0; i < 16; i++)
      begin
         word_q[0][i] = 24'h100000 + 24'(i);
         word_q[1][i] = 24'h200000 + 24'(i);
         flag_q[0][i] = 1'b0;
         flag_q[1][i] = 1'b1;
      end
   end
   always @(posedge ref_clk_i)
   begin
      if (mem_req_i && mem_op_i.xchg)
         word_q[t][a] <= mem_wdata_i;
      if (mem_req_i && mem_op_i.flag_wr)
         flag_q[t][a] <= mem_op_i.flag_val;
      // The host collects output only when the bench lets it.
      in_waiting_o <= host_in_i;
      out_pending_o <= host_out_i;
   end
endmodule : mem_host_model
`default_nettype wire
